/* pkg/cps_cfg.svh */
/*
  Offsets, field positions, speed codes and timing counts of the
  port status field bank. Included by the package and the design.
*/
`ifndef CPS_CFG_SVH
`define CPS_CFG_SVH

`define CPS_OFF_PSEL    4'h0
`define CPS_OFF_STAT    4'h4
`define CPS_OFF_ERR     4'h8

`define CPS_SPD_S100    3'h0
`define CPS_SPD_S200    3'h1
`define CPS_SPD_S400    3'h2
`define CPS_SPD_S800    3'h3
`define CPS_SPD_S1600   3'h4
`define CPS_SPD_S3200   3'h5

`define CPS_B_MAXSPD    0
`define CPS_B_LPP       3
`define CPS_B_CAPSPD    4
`define CPS_B_UNREL     7
`define CPS_B_NEWCOD    8
`define CPS_B_DORM      9
`define CPS_B_ALLOW     10
`define CPS_B_LOOP      11
`define CPS_B_STBY      12
`define CPS_B_SHUT      13
`define CPS_B_DIS       14
`define CPS_B_CON       15
`define CPS_B_RXV       16

`define CPS_ERR_MAX     8'hFF
`define CPS_DEB_MS      341
`define CPS_CLK_KHZ     25000
`define CPS_DEB_CYC     (`CPS_DEB_MS * `CPS_CLK_KHZ)

`endif

/* pkg/cps_pkg.sv */
/*
  Types of the port status field bank.
  Assumes cps_cfg.svh is on the include path.
*/
`include "cps_cfg.svh"

package cps_pkg;
  typedef enum logic [1:0] {
    CPS_BILINGUAL,
    CPS_NEW_ONLY,
    CPS_LEGACY_ONLY
  } cps_mode_e;
  typedef logic [2:0]  cps_speed_t;
  typedef logic [16:0] cps_stat_t;
endpackage

/* design/cps_port_status.sv */
/*
  Per-port status and control fields of a three-port cable transceiver,
  reached over a classic Wishbone slave with 32-bit data.
  Assumes the port state machines run on ref_clk and hand over their
  events as one-cycle pulses; only the sleep strap is asynchronous.
*/
// The Wishbone register port and the placing of the registers were chosen for this implementation.
// Contract
// R1: Speed codes 000..101, 110/111 reserved.
// R2: Overlarge speed write stores port capability.
// R3: Speed setting used at new-mode connect only; code also applies it every cycle on a new-only port.
// R4: Bilingual port fixed at S400, ignores writes.
// R5: Reset loads speed setting with capability.
// R6: Training speed never below minimum speed.
// R7: Local plug flag always reads 1.
// R8: Read-only capable speed field, same coding.
// R9: Unreliable flag set on failure, W1C.
// R10: New-mode indicator only while in new mode.
// R11: Legacy active shows connected, receive-valid, indicator 0.
// R12: Saturating 8-bit invalid codeword counter.
// R13: Counter cleared by local or remote read.
// R14: Sleep flag; sleep only when allowed.
// R15: Reset samples strap into every sleep allow.
// R16: Software may rewrite each sleep allow.
// R17: Power manager mode shows sleep on data.
// R18: Loop flag set by build, cleared reset/disconnect.
// R19: Standby flag while in standby state.
// R20: Shutdown plus disable forces connected/receive low.
// R21: Shutdown stops tones only on disabled port.
// R22: Software selects vendor page via register seven; code has no vendor page, offset 4'hC reads zero.
// R23: Disable control; hard reset clears, bus reset not.
// R24: Connected set after stable debounce time.
// R25: New mode receive-valid excludes tones-only time.
// R26: Separate fields per port, selected one shown.
`timescale 1ns/1ps
`default_nettype none
`include "cps_cfg.svh"

module cps_port_status #(
  parameter int                       NPORT     = 3,
  parameter logic [3*NPORT-1:0]       CAP_SPEED = {NPORT{`CPS_SPD_S400}},
  parameter logic [2*NPORT-1:0]       PORT_MODE = {2*NPORT{1'b0}},
  parameter logic [2:0]               MIN_SPEED = `CPS_SPD_S100,
  parameter int                       DEB_CYC   = `CPS_DEB_CYC
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic                   cyc,
  input  wire logic                   stb,
  input  wire logic                   we,
  input  wire logic [3:0]             sel,
  input  wire logic [31:0]            adr,
  input  wire logic [31:0]            dat_w,
  output logic      [31:0]            dat_r,
  output logic                        ack,
  input  wire logic                   dormant_strap_pin,
  input  wire logic                   power_manager_mode,
  input  wire logic                   link_present,
  input  wire logic                   bus_reset,
  input  wire logic [NPORT-1:0]       line_connect,
  input  wire logic [NPORT-1:0]       signal_valid,
  input  wire logic [NPORT-1:0]       tones_only,
  input  wire logic [NPORT-1:0]       new_mode_link,
  input  wire logic [NPORT-1:0]       conn_start,
  input  wire logic [NPORT-1:0]       speed_neg_fail,
  input  wire logic [NPORT-1:0]       sync_fail,
  input  wire logic [NPORT-1:0]       invalid_codeword,
  input  wire logic [NPORT-1:0]       sleep_state,
  input  wire logic [NPORT-1:0]       loop_block_set,
  input  wire logic [NPORT-1:0]       standby_state,
  input  wire logic                   remote_rd,
  input  wire logic [1:0]             remote_port,
  output logic      [7:0]             remote_data,
  output logic      [3*NPORT-1:0]     train_speed,
  output logic      [NPORT-1:0]       connected,
  output logic      [NPORT-1:0]       receive_valid,
  output logic      [NPORT-1:0]       port_enable,
  output logic      [NPORT-1:0]       tone_enable,
  output logic      [NPORT-1:0]       sleep_allowed,
  output logic      [NPORT-1:0]       pm_data,
  output logic                        pm_data_oe
);

  localparam int DEB_W = $clog2(DEB_CYC + 1);

  logic              strap_meta_reg;
  logic              strap_sync_reg;
  logic [1:0]        psel_reg;
  logic              ack_reg;
  logic [31:0]       dat_reg;
  logic [31:0]       dat_next;
  logic [7:0]        rem_reg;
  logic [7:0]        rem_next;

  cps_pkg::cps_stat_t stat_word [NPORT];
  logic [7:0]        err_word  [NPORT];

  wire               req      = cyc & stb;
  wire               acc      = req & ~ack_reg;
  wire               hit_psel = (adr[3:0] == `CPS_OFF_PSEL);
  wire               hit_stat = (adr[3:0] == `CPS_OFF_STAT);
  wire               hit_err  = (adr[3:0] == `CPS_OFF_ERR);
  wire               sel_ok   = (psel_reg < 2'(NPORT));
  wire               pm_show  = power_manager_mode & ~link_present;

  // Strap passes two flops; these run through reset so it can be caught
  always_ff @(posedge ref_clk) begin
    strap_meta_reg <= dormant_strap_pin;
    strap_sync_reg <= strap_meta_reg;
  end

  // Bus answers one cycle after the request; all effects at that edge
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
      rem_reg <= 8'h0;
    end else begin
      ack_reg <= acc;
      dat_reg <= acc ? dat_next : dat_reg;
      rem_reg <= rem_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      psel_reg <= 2'h0;
    end else if (acc && we && hit_psel && sel[0]) begin
      psel_reg <= dat_w[1:0];
    end
  end

  // Read mux shows the selected port only; unmapped reads give zero
  always_comb begin
    dat_next = 32'h0;
    if (!we) begin
      if (hit_psel) begin
        dat_next = {30'h0, psel_reg};
      end else if (hit_stat && sel_ok) begin
        dat_next = {15'h0, stat_word[psel_reg]}; // see R26
      end else if (hit_err && sel_ok) begin
        dat_next = {24'h0, err_word[psel_reg]};
      end
    end
  end

  always_comb begin
    rem_next = rem_reg;
    if (remote_rd && remote_port < 2'(NPORT)) begin
      rem_next = err_word[remote_port];
    end
  end

  assign ack         = ack_reg;
  assign dat_r       = dat_reg;
  assign remote_data = rem_reg;
  assign pm_data_oe  = pm_show; // see R17

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : port_g
      localparam logic [2:0] CAP  = CAP_SPEED[3*g +: 3];
      localparam cps_pkg::cps_mode_e MODE = cps_pkg::cps_mode_e'(PORT_MODE[2*g +: 2]);
      localparam logic       BILI = (MODE == cps_pkg::CPS_BILINGUAL);
      localparam logic       NEWO = (MODE == cps_pkg::CPS_NEW_ONLY);
      localparam logic [2:0] RST_SPD = BILI ? `CPS_SPD_S400 : CAP;

      logic [2:0]       max_spd_reg;
      logic [2:0]       train_reg;
      logic             unrel_reg;
      logic [7:0]       err_reg;
      logic             allow_reg;
      logic             loop_reg;
      logic             shut_reg;
      logic             dis_reg;
      logic             con_reg;
      logic [DEB_W-1:0] deb_reg;

      wire mine     = (psel_reg == 2'(g));
      wire wr_stat  = acc & we & hit_stat & mine;
      wire wr_b0    = wr_stat & sel[0];
      wire wr_b1    = wr_stat & sel[1];
      wire rd_err   = (acc & ~we & hit_err & mine) | (remote_rd & (remote_port == 2'(g)));
      wire [2:0] wr_spd = dat_w[`CPS_B_MAXSPD +: 3];
      // Reserved codes also exceed any capability and so clamp
      wire [2:0] spd_in = (wr_spd > CAP) ? CAP : wr_spd; // see R1, R2
      wire forced   = dis_reg & shut_reg;
      wire con_out  = con_reg & ~forced;
      wire rxv_raw  = new_mode_link[g] ? (signal_valid[g] & ~tones_only[g]) : signal_valid[g];
      wire rxv_out  = rxv_raw & ~dis_reg & ~forced; // see R25, R20
      wire newc     = new_mode_link[g] & con_out; // see R10, R11
      wire dorm     = sleep_state[g] & allow_reg; // see R14
      wire unrel_set = speed_neg_fail[g] | sync_fail[g];
      wire err_full = (err_reg == `CPS_ERR_MAX);
      wire [2:0] spd_eff = (max_spd_reg < MIN_SPEED) ? MIN_SPEED : max_spd_reg; // see R6

      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          max_spd_reg <= RST_SPD; // see R5
        end else if (wr_b0 && !BILI) begin
          max_spd_reg <= spd_in; // see R4
        end
      end

      // Setting reaches the port only at a new-mode connection or when new-mode only
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          train_reg <= RST_SPD;
        end else if (BILI) begin
          train_reg <= `CPS_SPD_S400; // see R4
        end else if (NEWO || (conn_start[g] && new_mode_link[g])) begin
          train_reg <= spd_eff; // see R3
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          unrel_reg <= 1'b0;
        end else if (unrel_set) begin
          unrel_reg <= 1'b1; // see R9
        end else if (wr_b0 && dat_w[`CPS_B_UNREL]) begin
          unrel_reg <= 1'b0; // see R9
        end
      end

      // A codeword arriving during the read clearing counts as one
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          err_reg <= 8'h0;
        end else if (rd_err) begin
          err_reg <= {7'h0, invalid_codeword[g]}; // see R13
        end else if (invalid_codeword[g] && !err_full) begin
          err_reg <= err_reg + 8'h1; // see R12
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          allow_reg <= strap_sync_reg; // see R15
        end else if (wr_b1) begin
          allow_reg <= dat_w[`CPS_B_ALLOW]; // see R16
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          loop_reg <= 1'b0;
        end else if (loop_block_set[g]) begin
          loop_reg <= 1'b1; // see R18
        end else if (bus_reset || !con_reg) begin
          loop_reg <= 1'b0; // see R18
        end
      end

      // Both controls survive bus reset
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          shut_reg <= 1'b0;
          dis_reg  <= 1'b0; // see R23
        end else if (wr_b1) begin
          shut_reg <= dat_w[`CPS_B_SHUT];
          dis_reg  <= dat_w[`CPS_B_DIS];
        end
      end

      // Debounce: line must stay connected for the full count
      always_ff @(posedge ref_clk) begin
        if (!rstn || !line_connect[g]) begin
          deb_reg <= '0;
          con_reg <= 1'b0;
        end else if (deb_reg == DEB_W'(DEB_CYC - 1)) begin
          con_reg <= 1'b1; // see R24
        end else begin
          deb_reg <= deb_reg + DEB_W'(1);
        end
      end

      assign stat_word[g] = {rxv_out, con_out, dis_reg, shut_reg,
                             standby_state[g], loop_reg, allow_reg, dorm, newc,
                             unrel_reg, CAP, 1'b1, max_spd_reg}; // see R7, R8, R19, R26
      assign err_word[g]  = err_reg;

      assign train_speed[3*g +: 3] = train_reg;
      assign connected[g]     = con_out; // see R20
      assign receive_valid[g] = rxv_out;
      assign port_enable[g]   = ~dis_reg; // see R23
      assign tone_enable[g]   = ~forced; // see R21
      assign sleep_allowed[g] = allow_reg; // see R14
      assign pm_data[g]       = pm_show & dorm; // see R17
    end
  endgenerate

endmodule
`default_nettype wire

/* test/cps_port_status_properties.sv */
/* Concurrent checks on the port status bank.
   Assumes one clock, ref_clk, and the synchronous active-low rstn. */
`timescale 1ns/1ps
`default_nettype none
`include "cps_cfg.svh"
module cps_port_status_chk #(
  parameter int         NPORT     = 3,
  parameter logic [2:0] MIN_SPEED = 3'h0
) (
  input wire logic               ref_clk,
  input wire logic               rstn,
  input wire logic               cyc,
  input wire logic               stb,
  input wire logic               ack,
  input wire logic               power_manager_mode,
  input wire logic               link_present,
  input wire logic [NPORT-1:0]   line_connect,
  input wire logic [NPORT-1:0]   tones_only,
  input wire logic [NPORT-1:0]   new_mode_link,
  input wire logic [NPORT-1:0]   sleep_state,
  input wire logic [3*NPORT-1:0] train_speed,
  input wire logic [NPORT-1:0]   connected,
  input wire logic [NPORT-1:0]   receive_valid,
  input wire logic [NPORT-1:0]   port_enable,
  input wire logic [NPORT-1:0]   tone_enable,
  input wire logic [NPORT-1:0]   sleep_allowed,
  input wire logic [NPORT-1:0]   pm_data,
  input wire logic               pm_data_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  bus_answer_a: assert property (cyc && stb && !ack |=> ack)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  bilingual_speed_a: assert property (train_speed[2:0] == `CPS_SPD_S400)
    else $error("bilingual port left S400");
  // Port 1 is the new-only port in the bench
  min_speed_a: assert property (train_speed[5:3] >= MIN_SPEED)
    else $error("training below minimum speed");
  connect_debounce_a: assert property ($rose(connected[0])
    |-> $past(line_connect[0]) && $past(line_connect[0], 3))
    else $error("connected without stable line");
  shutdown_force_a: assert property (
    (~port_enable & ~tone_enable & (connected | receive_valid)) == 3'h0)
    else $error("shut port shows link");
  shutdown_tone_a: assert property ((port_enable & ~tone_enable) == 3'h0)
    else $error("tones stopped on enabled port");
  disabled_rx_a: assert property ((~port_enable & receive_valid) == 3'h0)
    else $error("disabled port receive valid");
  tones_rx_a: assert property ((new_mode_link & tones_only & receive_valid) == 3'h0)
    else $error("receive valid on tones only");
  pm_show_a: assert property (pm_data_oe == (power_manager_mode && !link_present)
    && (!pm_data_oe || pm_data == (sleep_state & sleep_allowed)))
    else $error("sleep monitor output wrong");
endmodule
bind cps_port_status cps_port_status_chk #(.NPORT(NPORT), .MIN_SPEED(MIN_SPEED)) chk_i (
  .ref_clk(ref_clk), .rstn(rstn), .cyc(cyc), .stb(stb), .ack(ack),
  .power_manager_mode(power_manager_mode), .link_present(link_present),
  .line_connect(line_connect), .tones_only(tones_only), .new_mode_link(new_mode_link),
  .sleep_state(sleep_state), .train_speed(train_speed), .connected(connected),
  .receive_valid(receive_valid), .port_enable(port_enable), .tone_enable(tone_enable),
  .sleep_allowed(sleep_allowed), .pm_data(pm_data), .pm_data_oe(pm_data_oe));
`default_nettype wire

/* test/cps_link_model.sv */
/* Link controller model: classic Wishbone master.
   Assumes callers enter xfer just after a rising ref_clk edge. */
`timescale 1ns/1ps
`default_nettype none
module cps_link_model (
  input  wire logic        ref_clk,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [3:0]       sel,
  output logic [31:0]      adr,
  output logic [31:0]      dat_w,
  input  wire logic [31:0] dat_r,
  input  wire logic        ack
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 32'h0;
    dat_w = 32'h0;
  end
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= {28'h0, a};
    dat_w <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = dat_r;
    ok = (ack === 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    // Released lines carry a changed value, not the old request
    adr <= ~{28'h0, a};
    dat_w <= ~d;
    @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* test/test_cps_port_status.sv */
/* Self-checking bench of the port status bank.
   Assumes the bind in the properties file and the link model. */
`timescale 1ns/1ps
`default_nettype none
module test_cps_port_status;
  localparam logic [8:0] CAP = 9'h09A;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc, stb, we, ack, pm_data_oe;
  logic [3:0] sel;
  logic [31:0] adr, dat_w, dat_r, q;
  logic dormant_strap_pin = 1'b1, power_manager_mode = 1'b0, link_present = 1'b1;
  logic bus_reset = 1'b0, remote_rd = 1'b0;
  logic [1:0] remote_port = 2'h0;
  logic [2:0] line_connect = 3'h0, signal_valid = 3'h0, tones_only = 3'h0;
  logic [2:0] new_mode_link = 3'h0, conn_start = 3'h0, speed_neg_fail = 3'h0;
  logic [2:0] sync_fail = 3'h0, invalid_codeword = 3'h0, sleep_state = 3'h0;
  logic [2:0] loop_block_set = 3'h0, standby_state = 3'h0;
  logic [2:0] connected, receive_valid, port_enable, tone_enable, sleep_allowed, pm_data;
  logic [7:0] remote_data;
  logic [8:0] train_speed;
  logic [2:0] wv [5] = '{3'h0, 3'h7, 3'h6, 3'h4, 3'h1};
  logic [2:0] ev [5] = '{3'h0, 3'h3, 3'h3, 3'h3, 3'h1};
  int mismatches = 0;
  int cmp_count = 0;
  always #20 ref_clk = ~ref_clk;
  cps_port_status #(.CAP_SPEED(CAP), .PORT_MODE(6'h24), .MIN_SPEED(3'h1), .DEB_CYC(4)) uut (.*);
  cps_link_model link (.*);
  task automatic complete_run();
    $display("%0d comparisons, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic ok;
    link.xfer(w, a, d, q, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask
  // Select a port, then read its status word
  task automatic st(input logic [1:0] p);
    acc(1'b1, 4'h0, {30'h0, p});
    acc(1'b0, 4'h4, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    for (int p = 0; p < 3; p++) begin
      st(p[1:0]);
      chk(q[6:0], {CAP[3*p+:3], 1'b1, CAP[3*p+:3]});
      chk(q & 32'hFFFF_FF80, {21'h0, 1'b1, 10'h0});
    end
    $display("test reset done");
    st(2'h1);
    foreach (wv[i]) begin
      acc(1'b1, 4'h4, {29'h80, wv[i]});
      acc(1'b0, 4'h4, 32'h0);
      chk(q[2:0], ev[i]);
      chk(train_speed[5:3], (ev[i] < 3'h1) ? 3'h1 : ev[i]);
    end
    st(2'h0);
    acc(1'b1, 4'h4, 32'h400);
    acc(1'b0, 4'h4, 32'h0);
    chk(q[2:0], 3'h2);
    $display("test speed done");
    st(2'h2);
    acc(1'b1, 4'h4, 32'h0);
    sleep_state <= 3'h7;
    power_manager_mode <= 1'b1;
    link_present <= 1'b0;
    acc(1'b0, 4'h4, 32'h0);
    chk(q[10:9], 2'h0);
    chk({pm_data_oe, pm_data}, 4'hB);
    st(2'h0);
    chk(q[10:9], 2'h3);
    chk(train_speed[8:6], 3'h2);
    conn_start <= 3'h4;
    new_mode_link <= 3'h4;
    @(posedge ref_clk);
    conn_start <= 3'h0;
    new_mode_link <= 3'h0;
    @(posedge ref_clk);
    chk(train_speed[8:6], 3'h1);
    $display("test sleep done");
    invalid_codeword <= 3'h1;
    repeat (260) @(posedge ref_clk);
    invalid_codeword <= 3'h0;
    acc(1'b0, 4'h8, 32'h0);
    chk(q, 32'hFF);
    acc(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    invalid_codeword <= 3'h1;
    repeat (3) @(posedge ref_clk);
    invalid_codeword <= 3'h0;
    remote_rd <= 1'b1;
    @(posedge ref_clk);
    remote_rd <= 1'b0;
    @(posedge ref_clk);
    chk(remote_data, 8'h3);
    acc(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    $display("test counter done");
    st(2'h1);
    speed_neg_fail <= 3'h2;
    @(posedge ref_clk);
    speed_neg_fail <= 3'h0;
    acc(1'b0, 4'h4, 32'h0);
    chk(q[7], 1'b1);
    acc(1'b1, 4'h4, 32'h481);
    acc(1'b0, 4'h4, 32'h0);
    chk(q[7], 1'b0);
    sync_fail <= 3'h2;
    @(posedge ref_clk);
    sync_fail <= 3'h0;
    acc(1'b0, 4'h4, 32'h0);
    chk(q[7], 1'b1);
    $display("test unreliable done");
    line_connect <= 3'h5;
    signal_valid <= 3'h5;
    new_mode_link <= 3'h1;
    tones_only <= 3'h1;
    repeat (8) @(posedge ref_clk);
    st(2'h2);
    chk({q[16:15], q[8]}, 3'h6);
    st(2'h0);
    chk({q[16:15], q[8]}, 3'h3);
    tones_only <= 3'h0;
    loop_block_set <= 3'h1;
    standby_state <= 3'h1;
    @(posedge ref_clk);
    loop_block_set <= 3'h0;
    acc(1'b0, 4'h4, 32'h0);
    chk({q[16], q[12:11]}, 3'h7);
    bus_reset <= 1'b1;
    @(posedge ref_clk);
    bus_reset <= 1'b0;
    acc(1'b0, 4'h4, 32'h0);
    chk(q[11], 1'b0);
    acc(1'b1, 4'h4, 32'h6402);
    chk({connected[0], receive_valid[0], tone_enable[0]}, 3'h0);
    acc(1'b1, 4'h4, 32'h4402);
    chk({port_enable[0], receive_valid[0], tone_enable[0]}, 3'h1);
    acc(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    $display("test connection done");
    complete_run();
  end
endmodule
`default_nettype wire
